//--- hw/adcc_pkg.sv
// package: register map, field positions and reset values
package adcc_pkg;
    localparam int unsigned RES_W          = 12;
    // register byte addresses
    localparam logic [4:0]  ADDR_RESULT_LOW  = 5'h00;
    localparam logic [4:0]  ADDR_RESULT_HIGH = 5'h04;
    localparam logic [4:0]  ADDR_CONV_CTRL   = 5'h08;
    localparam logic [4:0]  ADDR_SRC_CLK     = 5'h0c;
    localparam logic [4:0]  ADDR_REF_AMP     = 5'h10;
    localparam logic [4:0]  ADDR_BANDGAP     = 5'h14;
    // conversion_control field positions
    localparam int unsigned BIT_START        = 7;
    localparam int unsigned BIT_BUSY         = 6;
    localparam int unsigned BIT_ENABLE       = 5;
    localparam int unsigned BIT_JUSTIFY      = 4;
    // reference_amp_control field positions
    localparam int unsigned BIT_AMP_EN       = 7;
    localparam int unsigned BIT_AMP_IN       = 4;
    // reset values
    localparam logic [7:0]  RST_CONV_CTRL    = 8'h00;
    localparam logic [7:0]  RST_SRC_CLK      = 8'h00;
    localparam logic [7:0]  RST_REF_AMP      = 8'h00;
    localparam logic [7:0]  RST_BANDGAP      = 8'h00;
    localparam logic [7:0]  RST_RESULT       = 8'h00;
    // writable masks (unimplemented bits read zero)
    localparam logic [7:0]  MASK_CONV_CTRL   = 8'hbf;
    localparam logic [7:0]  MASK_SRC_CLK     = 8'hf7;
    localparam logic [7:0]  MASK_REF_AMP     = 8'h9f;
    localparam logic [7:0]  MASK_BANDGAP     = 8'h01;
    // axi responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage : adcc_pkg

//--- hw/adcc_clkdiv.sv
// conversion clock divider: one-cycle tick every 2**code system clocks
`timescale 1ns/1ps
module adcc_clkdiv #(
    parameter int unsigned CODE_W = 3
) (
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              run_in,
    input  wire logic [CODE_W-1:0] code_in,
    output logic                   tick_out
);
    localparam int unsigned CNT_W = (1 << CODE_W) - 1;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] limit;

    // divisor is 2**code; the counter restarts when the converter is idle
    always_comb begin
        limit = CNT_W'((1 << code_in) - 1);
        if (!run_in || count >= limit) begin
            next_count = '0;
        end else begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign tick_out = run_in && (count >= limit);
endmodule : adcc_clkdiv

//--- hw/adcc_top.sv
// converter control top: register file, start sequencing, analog routing
// Functional notes
// RL1 - every result is a 12-bit unsigned value
// RL2 - justify 0: high byte bits 11..4, low byte upper nibble 3..0
// RL3 - justify 1: high byte low nibble 11..8, low byte 7..0
// RL4 - positions without a result bit read zero
// RL5 - a disabled converter leaves both result registers unchanged
// RL6 - start bit written low-high-low begins one conversion; resets 0
// RL7 - busy bit 6 sets on start, clears on completion
// RL8 - enable bit 5 powers the converter; resets 0
// RL9 - channel codes 0..7 route that channel; 8..15 float
// RL10 - source codes: external, supply or amplifier fractions, ground
// RL11 - an internal source disconnects the external channel path
// RL12 - clock field divides system clock by two to the code
// RL13 - reference: supply, external pin, amplifier; internal drops pin
// RL14 - amplifier input: pin when 0, bandgap when 1 disconnecting the pin
// RL15 - third control register bit 7 enables the gain amplifier; resets 0
// RL16 - analog input pins lose shared function and pull-high
// RL17 - unimplemented bits read zero; control bits reset zero
// RL18 - completion sets the request flag and clears busy
// RL19 - bandgap register bit 0 enables the bandgap; upper bits read zero
// RL20 - results load in the cycle busy clears
// RL21 - a start during a running conversion is ignored
`timescale 1ns/1ps
module adcc_top #(
    parameter int unsigned NUM_CH = 8
) (
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    // axi4-lite slave
    input  wire logic [4:0]          s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    output logic [1:0]               s_axi_bresp_out,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    input  wire logic [4:0]          s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in,
    // converter core
    output logic                     core_power_out,
    output logic                     core_clk_tick_out,
    output logic                     core_start_out,
    input  wire logic                core_done_in,
    input  wire logic [11:0]         core_result_in,
    // analog routing controls
    output logic [NUM_CH-1:0]        channel_connect_out,
    output logic [NUM_CH-1:0]        pin_analog_mode_out,
    output logic [NUM_CH-1:0]        pin_pullup_disable_out,
    output logic [2:0]               internal_signal_select_out,
    output logic                     internal_path_on_out,
    output logic                     ground_select_out,
    output logic [1:0]               reference_source_select_out,
    output logic                     ext_reference_pin_on_out,
    output logic                     gain_amp_enable_out,
    output logic                     gain_amp_input_select_out,
    output logic                     amp_reference_input_pin_on_out,
    output logic [1:0]               gain_amp_gain_select_out,
    output logic                     bandgap_enable_out,
    input  wire logic [NUM_CH-1:0]   pin_analog_assign_in,
    output logic                     conversion_irq_flag_out
);
    // reset release: asynchronous assert, two-flop release
    logic rst_sync1;
    logic rst_b;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync1 <= 1'b0;
            rst_b     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_b     <= rst_sync1;
        end
    end

    // register state
    logic [7:0]  conv_ctrl;
    logic [7:0]  next_conv_ctrl;
    logic [7:0]  src_clk;
    logic [7:0]  next_src_clk;
    logic [7:0]  ref_amp;
    logic [7:0]  next_ref_amp;
    logic [7:0]  bandgap;
    logic [7:0]  next_bandgap;
    logic [11:0] result;
    logic [11:0] next_result;
    logic        busy;
    logic        next_busy;
    logic        start_armed;
    logic        next_start_armed;
    logic        irq_flag;
    logic        next_irq_flag;

    // axi state
    logic        aw_held;
    logic        next_aw_held;
    logic [4:0]  aw_addr;
    logic [4:0]  next_aw_addr;
    logic        w_held;
    logic        next_w_held;
    logic [7:0]  w_byte;
    logic [7:0]  next_w_byte;
    logic        w_lane0;
    logic        next_w_lane0;
    logic        bvalid;
    logic        next_bvalid;
    logic [1:0]  bresp;
    logic [1:0]  next_bresp;
    logic        rvalid;
    logic        next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0]  rresp;
    logic [1:0]  next_rresp;

    logic        do_write;
    logic        do_read;
    logic        start_seq_done;
    logic        div_tick;
    logic        enabled;
    logic        justify;
    logic        ext_selected;
    logic [7:0]  result_low;
    logic [7:0]  result_high;
    logic [7:0]  read_byte;
    logic        read_hit;
    logic        write_hit;

    assign enabled = conv_ctrl[adcc_pkg::BIT_ENABLE];
    assign justify = conv_ctrl[adcc_pkg::BIT_JUSTIFY];

    // result formatting; empty positions are constant zero
    always_comb begin
        if (justify) begin
            result_high = {4'h0, result[11:8]}; // [RL3] [RL4]
            result_low  = result[7:0]; // [RL3]
        end else begin
            result_high = result[11:4]; // [RL2]
            result_low  = {result[3:0], 4'h0}; // [RL2] [RL4]
        end
    end

    // write channel: aw and w taken apart, answer once both held
    assign s_axi_awready_out = !aw_held && !bvalid;
    assign s_axi_wready_out  = !w_held && !bvalid;
    assign do_write          = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_byte  = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_w_held  = 1'b1;
            next_w_byte  = s_axi_wdata_in[7:0];
            next_w_lane0 = s_axi_wstrb_in[0];
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = write_hit ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
        end else if (bvalid && s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
    end

    // decode: writes to result or unmapped offsets get slverr
    always_comb begin
        unique case (aw_addr)
            adcc_pkg::ADDR_CONV_CTRL,
            adcc_pkg::ADDR_SRC_CLK,
            adcc_pkg::ADDR_REF_AMP,
            adcc_pkg::ADDR_BANDGAP: write_hit = 1'b1;
            default:                write_hit = 1'b0;
        endcase
    end

    // control registers; only byte lane 0 carries data, masked bits stay zero
    always_comb begin
        next_conv_ctrl = conv_ctrl;
        next_src_clk   = src_clk;
        next_ref_amp   = ref_amp;
        next_bandgap   = bandgap;
        if (do_write && w_lane0) begin
            unique case (aw_addr)
                adcc_pkg::ADDR_CONV_CTRL: next_conv_ctrl = w_byte & adcc_pkg::MASK_CONV_CTRL; // [RL17]
                adcc_pkg::ADDR_SRC_CLK:   next_src_clk   = w_byte & adcc_pkg::MASK_SRC_CLK;   // [RL17]
                adcc_pkg::ADDR_REF_AMP:   next_ref_amp   = w_byte & adcc_pkg::MASK_REF_AMP;   // [RL17]
                adcc_pkg::ADDR_BANDGAP:   next_bandgap   = w_byte & adcc_pkg::MASK_BANDGAP;   // [RL19]
                default:                  ;
            endcase
        end
    end

    // start sequence: a written high arms, the following written low fires
    assign start_seq_done = do_write && w_lane0 && (aw_addr == adcc_pkg::ADDR_CONV_CTRL)
                            && start_armed && !w_byte[adcc_pkg::BIT_START]; // [RL6]

    // conversion sequencing
    always_comb begin
        next_start_armed = start_armed;
        next_busy        = busy;
        next_result      = result;
        next_irq_flag    = irq_flag;
        core_start_out   = 1'b0;
        if (do_write && w_lane0 && aw_addr == adcc_pkg::ADDR_CONV_CTRL) begin
            next_start_armed = w_byte[adcc_pkg::BIT_START]; // [RL6]
        end
        // reading the control register clears the request flag; a completion wins
        if (do_read && s_axi_araddr_in == adcc_pkg::ADDR_CONV_CTRL) begin
            next_irq_flag = 1'b0;
        end
        if (!enabled) begin
            next_busy = 1'b0; // [RL8] [RL5]
        end else if (busy) begin
            if (core_done_in) begin
                next_busy     = 1'b0; // [RL7] [RL20]
                next_result   = core_result_in; // [RL1] [RL20]
                next_irq_flag = 1'b1; // [RL18]
            end
            // a start while busy is dropped [RL21]
        end else if (start_seq_done) begin
            next_busy      = 1'b1; // [RL7]
            core_start_out = 1'b1; // [RL6]
        end
    end

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            conv_ctrl   <= adcc_pkg::RST_CONV_CTRL; // [RL17]
            src_clk     <= adcc_pkg::RST_SRC_CLK;
            ref_amp     <= adcc_pkg::RST_REF_AMP; // [RL15]
            bandgap     <= adcc_pkg::RST_BANDGAP; // [RL19]
            result      <= {adcc_pkg::RST_RESULT[3:0], adcc_pkg::RST_RESULT};
            busy        <= 1'b0;
            start_armed <= 1'b0;
            irq_flag    <= 1'b0;
            aw_held     <= 1'b0;
            aw_addr     <= 5'h00;
            w_held      <= 1'b0;
            w_byte      <= 8'h00;
            w_lane0     <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= adcc_pkg::RESP_OKAY;
            rvalid      <= 1'b0;
            rdata       <= 32'h0000_0000;
            rresp       <= adcc_pkg::RESP_OKAY;
        end else begin
            conv_ctrl   <= next_conv_ctrl;
            src_clk     <= next_src_clk;
            ref_amp     <= next_ref_amp;
            bandgap     <= next_bandgap;
            result      <= next_result;
            busy        <= next_busy;
            start_armed <= next_start_armed;
            irq_flag    <= next_irq_flag;
            aw_held     <= next_aw_held;
            aw_addr     <= next_aw_addr;
            w_held      <= next_w_held;
            w_byte      <= next_w_byte;
            w_lane0     <= next_w_lane0;
            bvalid      <= next_bvalid;
            bresp       <= next_bresp;
            rvalid      <= next_rvalid;
            rdata       <= next_rdata;
            rresp       <= next_rresp;
        end
    end

    // read channel: one read at a time, data registered one cycle after address
    assign s_axi_arready_out = !rvalid;
    assign do_read           = s_axi_arvalid_in && !rvalid;

    always_comb begin
        read_hit = 1'b1;
        unique case (s_axi_araddr_in)
            adcc_pkg::ADDR_RESULT_LOW:  read_byte = result_low;
            adcc_pkg::ADDR_RESULT_HIGH: read_byte = result_high;
            adcc_pkg::ADDR_CONV_CTRL:   read_byte = {conv_ctrl[7], busy, conv_ctrl[5:0]}; // [RL7]
            adcc_pkg::ADDR_SRC_CLK:     read_byte = src_clk;
            adcc_pkg::ADDR_REF_AMP:     read_byte = ref_amp;
            adcc_pkg::ADDR_BANDGAP:     read_byte = bandgap;
            default: begin
                read_byte = 8'h00;
                read_hit  = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rdata  = {24'h00_0000, read_byte};
            next_rresp  = read_hit ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
        end else if (rvalid && s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid;
    assign s_axi_bresp_out  = bresp;
    assign s_axi_rvalid_out = rvalid;
    assign s_axi_rdata_out  = rdata;
    assign s_axi_rresp_out  = rresp;

    // conversion clock ticks only while a conversion runs, saving switching power
    adcc_clkdiv #(
        .CODE_W (3)
    ) u_clkdiv (
        .clk_in   (clk_in),
        .rst_b_in (rst_b),
        .run_in   (busy),
        .code_in  (src_clk[2:0]), // [RL12]
        .tick_out (div_tick)
    );

    // analog routing; codes 0000, 0100 and 11xx pick the external channel
    always_comb begin
        ext_selected = (src_clk[7:4] == 4'h0) || (src_clk[7:4] == 4'h4)
                       || (src_clk[7:6] == 2'b11); // [RL10]
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            // codes 8..15 match no channel, leaving the converter input floating
            assign channel_connect_out[ch] = enabled && ext_selected
                                             && (conv_ctrl[3:0] == 4'(ch)); // [RL9] [RL11]
            assign pin_analog_mode_out[ch]    = pin_analog_assign_in[ch];   // [RL16]
            assign pin_pullup_disable_out[ch] = pin_analog_assign_in[ch];   // [RL16]
        end
    endgenerate

    assign core_power_out             = enabled; // [RL8]
    assign core_clk_tick_out          = div_tick;
    assign internal_path_on_out       = enabled && !ext_selected && (src_clk[7:6] != 2'b10); // [RL11]
    assign ground_select_out          = src_clk[7:6] == 2'b10; // [RL10]
    assign internal_signal_select_out = src_clk[6:4]; // [RL10]
    assign reference_source_select_out = ref_amp[3:2]; // [RL13]
    assign ext_reference_pin_on_out   = ref_amp[3:2] == 2'b01; // [RL13]
    assign gain_amp_enable_out        = ref_amp[adcc_pkg::BIT_AMP_EN]; // [RL15]
    assign gain_amp_input_select_out  = ref_amp[adcc_pkg::BIT_AMP_IN]; // [RL14]
    assign amp_reference_input_pin_on_out = !ref_amp[adcc_pkg::BIT_AMP_IN]; // [RL14]
    assign gain_amp_gain_select_out   = ref_amp[1:0];
    assign bandgap_enable_out         = bandgap[0]; // [RL19]
    assign conversion_irq_flag_out    = irq_flag; // [RL18]
endmodule : adcc_top

//--- tb/adcc_top_assertions.sv
// checker: port-level properties of the converter block
`timescale 1ns/1ps
module adcc_top_assertions #(
    parameter int unsigned NUM_CH = 8
) (
    input wire logic              clk_in,
    input wire logic              rst_b_in,
    input wire logic              s_axi_bvalid_out,
    input wire logic              s_axi_bready_in,
    input wire logic [1:0]        s_axi_bresp_out,
    input wire logic              core_power_out,
    input wire logic              core_clk_tick_out,
    input wire logic              core_start_out,
    input wire logic              core_done_in,
    input wire logic [NUM_CH-1:0] channel_connect_out,
    input wire logic [NUM_CH-1:0] pin_analog_assign_in,
    input wire logic [NUM_CH-1:0] pin_pullup_disable_out,
    input wire logic              internal_path_on_out,
    input wire logic              ground_select_out,
    input wire logic [1:0]        reference_source_select_out,
    input wire logic              ext_reference_pin_on_out,
    input wire logic              gain_amp_input_select_out,
    input wire logic              amp_reference_input_pin_on_out,
    input wire logic              conversion_irq_flag_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic busy_m;
    // shadow busy: set by a start pulse, cleared by completion or power-off
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) busy_m <= 1'b0;
        else busy_m <= core_start_out | (busy_m & ~core_done_in & core_power_out);
    end
    sequence s_fire; core_start_out; endsequence
    sequence s_finish; busy_m && core_done_in; endsequence
    a_start_one_cycle: assert property (s_fire |=> !core_start_out)
        else $error("start pulse too long");
    a_start_idle_only: assert property (s_fire |-> core_power_out && !busy_m)
        else $error("start while busy or off");
    a_done_sets_irq: assert property (s_finish |=> conversion_irq_flag_out)
        else $error("request flag not set");
    a_tick_when_busy: assert property (core_clk_tick_out |-> busy_m)
        else $error("tick outside a conversion");
    a_chan_one_hot: assert property ($onehot0(channel_connect_out))
        else $error("several channels closed");
    a_chan_needs_power: assert property (channel_connect_out != '0 |-> core_power_out)
        else $error("channel on while off");
    a_internal_drops_ext: assert property (internal_path_on_out || ground_select_out
        |-> channel_connect_out == '0)
        else $error("channel on with internal source");
    a_pullup_follows: assert property (pin_pullup_disable_out == pin_analog_assign_in)
        else $error("pull-high kept on analog pin");
    a_ref_pin_code: assert property (ext_reference_pin_on_out
        == (reference_source_select_out == 2'h1))
        else $error("reference pin mismatch");
    a_amp_pin_select: assert property (amp_reference_input_pin_on_out
        == !gain_amp_input_select_out)
        else $error("amplifier pin mismatch");
    a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("response dropped early");
endmodule : adcc_top_assertions
bind adcc_top adcc_top_assertions #(.NUM_CH(NUM_CH)) u_chk (.*);

//--- tb/adcc_core_model.sv
// converter core model: counts ticks after a start, then reports a result
`timescale 1ns/1ps
module adcc_core_model #(
    parameter int unsigned TICKS = 8
) (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        power_in,
    input  wire logic        tick_in,
    input  wire logic        start_in,
    input  wire logic [11:0] sample_in,
    output logic             done_out,
    output logic [11:0]      result_out
);
    int unsigned left;
    // a powered-down core loses its conversion and never answers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) left <= 0;
        else if (!power_in) left <= 0;
        else if (start_in) left <= TICKS;
        else if (tick_in && left != 0) left <= left - 1;
        if (!rst_b_in) done_out <= 1'b0;
        else done_out <= power_in && tick_in && left == 1;
    end
    // outside done the bus carries the inverted sample, never a stale valid value
    assign result_out = done_out ? sample_in : ~sample_in;
endmodule : adcc_core_model

//--- tb/adc_control_register_logic_tb_top.sv
// testbench: register-level tests of the converter control block
`timescale 1ns/1ps
module adc_control_register_logic_tb_top;
    logic        clk_in = 1'b0, rst_b_in = 1'b0;
    logic [4:0]  s_axi_awaddr_in = 5'h00, s_axi_araddr_in = 5'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in = 4'hf;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic        s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, reference_source_select_out;
    logic [1:0]  gain_amp_gain_select_out;
    logic        core_power_out, core_clk_tick_out, core_start_out, core_done_in;
    logic [11:0] core_result_in, sample = 12'h000;
    logic [7:0]  channel_connect_out, pin_analog_mode_out, pin_pullup_disable_out;
    logic [7:0]  pin_analog_assign_in = 8'ha5;
    logic [2:0]  internal_signal_select_out;
    logic        internal_path_on_out, ground_select_out, ext_reference_pin_on_out;
    logic        gain_amp_enable_out, gain_amp_input_select_out, bandgap_enable_out;
    logic        amp_reference_input_pin_on_out, conversion_irq_flag_out;
    int          miscompares = 0, check_count = 0;
    logic [7:0]  after_ff [7] = '{8'h00, 8'h00, 8'hbf, 8'hf7, 8'h9f, 8'h01, 8'h00};

    adcc_top u_dut (.*);
    adcc_core_model #(.TICKS(8)) u_core (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .power_in(core_power_out), .tick_in(core_clk_tick_out), .start_in(core_start_out),
        .sample_in(sample), .done_out(core_done_in), .result_out(core_result_in));

    // 100 MHz system clock
    always #5 clk_in = ~clk_in;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // write: aw and w offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, got;
        logic [1:0] r;
        @(posedge clk_in);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= {24'h0, d};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        s_axi_bready_in  <= 1'b1;
        do begin
            @(negedge clk_in);
            ta = s_axi_awvalid_in && s_axi_awready_out;
            tw = s_axi_wvalid_in && s_axi_wready_out;
            got = s_axi_bvalid_out;
            r = s_axi_bresp_out;
            @(posedge clk_in);
            if (ta) s_axi_awvalid_in <= 1'b0;
            if (tw) s_axi_wvalid_in <= 1'b0;
        end while (!got);
        s_axi_bready_in <= 1'b0;
        chk("bresp", 32'(er), 32'(r));
    endtask : wr

    // read: values are captured in the cycle before the handshake edge
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ta, got;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk_in);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in  <= 1'b1;
        do begin
            @(negedge clk_in);
            ta = s_axi_arvalid_in && s_axi_arready_out;
            got = s_axi_rvalid_out;
            d = s_axi_rdata_out;
            r = s_axi_rresp_out;
            @(posedge clk_in);
            if (ta) s_axi_arvalid_in <= 1'b0;
        end while (!got);
        s_axi_rready_in <= 1'b0;
        chk("rresp", 32'(er), 32'(r));
        chk("rdata", {24'h0, e}, d);
    endtask : rd

    // one conversion on channel 3 plus an ignored start while busy
    task automatic conv(input logic j, input logic [11:0] v);
        int n;
        sample <= v;
        wr(5'h08, {3'b001, j, 4'h3}, 2'h0);
        wr(5'h08, {3'b101, j, 4'h3}, 2'h0);
        wr(5'h08, {3'b001, j, 4'h3}, 2'h0);
        rd(5'h08, {3'b011, j, 4'h3}, 2'h0);
        wr(5'h08, {3'b101, j, 4'h3}, 2'h0);
        wr(5'h08, {3'b001, j, 4'h3}, 2'h0);
        rd(5'h08, {3'b011, j, 4'h3}, 2'h0);
        for (n = 0; n < 2000 && conversion_irq_flag_out !== 1'b1; n++) @(posedge clk_in);
        chk("irq", 32'h1, 32'(conversion_irq_flag_out));
        rd(5'h08, {3'b001, j, 4'h3}, 2'h0);
        rd(5'h04, j ? {4'h0, v[11:8]} : v[11:4], 2'h0);
        rd(5'h00, j ? v[7:0] : {v[3:0], 4'h0}, 2'h0);
    endtask : conv

    task automatic results;
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    // cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        results();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        for (int i = 0; i < 7; i++) begin
            rd(5'(i * 4), 8'h00, i == 6 ? 2'h2 : 2'h0);
            wr(5'(i * 4), 8'hff, (i < 2 || i == 6) ? 2'h2 : 2'h0);
            rd(5'(i * 4), after_ff[i], i == 6 ? 2'h2 : 2'h0);
        end
        chk("amp_en", 32'h1, 32'(gain_amp_enable_out));
        chk("bandgap", 32'h1, 32'(bandgap_enable_out));
        chk("ref_pin", 32'h0, 32'(ext_reference_pin_on_out));
        chk("gain", 32'h3, 32'(gain_amp_gain_select_out));
        wr(5'h08, 8'h00, 2'h0);
        wr(5'h10, 8'h00, 2'h0);
        chk("amp_en", 32'h0, 32'(gain_amp_enable_out));
        wr(5'h08, 8'h23, 2'h0);
        for (int c = 0; c < 16; c++) begin
            wr(5'h0c, {4'(c), 4'h0}, 2'h0);
            chk("channel", (c == 0 || c == 4 || c >= 12) ? 32'h8 : 32'h0,
                32'(channel_connect_out));
            chk("ground", 32'(c / 4 == 2), 32'(ground_select_out));
            chk("isel", 32'(c % 8), 32'(internal_signal_select_out));
        end
        wr(5'h0c, 8'h03, 2'h0);
        wr(5'h08, 8'h28, 2'h0);
        chk("channel", 32'h0, 32'(channel_connect_out));
        chk("pullup", 32'ha5, 32'(pin_pullup_disable_out));
        pin_analog_assign_in <= 8'h3c;
        conv(1'b0, 12'habc);
        conv(1'b1, 12'h5e7);
        conv(1'b0, 12'hfff);
        chk("pin_mode", 32'h3c, 32'(pin_analog_mode_out));
        wr(5'h08, 8'h00, 2'h0);
        chk("power", 32'h0, 32'(core_power_out));
        sample <= 12'h123;
        wr(5'h08, 8'h80, 2'h0);
        wr(5'h08, 8'h00, 2'h0);
        repeat (100) @(posedge clk_in);
        rd(5'h04, 8'hff, 2'h0);
        rd(5'h00, 8'hf0, 2'h0);
        results();
    end
endmodule : adc_control_register_logic_tb_top
